// [shared/ctx_claim_pkg.sv]
// Package: register map, field layout and carriers for the context claim block
package ctx_claim_pkg;

    // --------------------------------------------------------------------
    // Sizes
    // --------------------------------------------------------------------
    localparam int NUM_CTX       = 5;
    localparam int CTX_ID_WIDTH  = 3;
    localparam int OBJ_WIDTH     = 12;
    localparam int PRIO_WIDTH    = 3;
    localparam int IDLE_WIDTH    = 24;
    localparam int IDLE_DIV      = 16;
    localparam int DIV_WIDTH     = 4;
    localparam int ADDR_WIDTH    = 8;

    // --------------------------------------------------------------------
    // Register byte offsets (per-context banks step by CTX_STRIDE)
    // --------------------------------------------------------------------
    localparam logic [7:0] TIMER_ENABLE_OFFSET = 8'h00;
    localparam logic [7:0] TIMER_CLEAR_OFFSET  = 8'h04;
    localparam logic [7:0] IDLE_COUNT_OFFSET   = 8'h08;
    localparam logic [7:0] CLAIM_BASE          = 8'h20;
    localparam logic [7:0] INHERIT_BASE        = 8'h40;
    localparam logic [7:0] PENDING_BASE        = 8'h60;
    localparam logic [7:0] IRQ_CONTROL_BASE    = 8'h80;
    localparam logic [7:0] IRQ_MAILBOX_BASE    = 8'hA0;
    localparam logic [7:0] CTX_STRIDE          = 8'h04;
    localparam logic [7:0] BANK_MASK           = 8'hE0;

    // --------------------------------------------------------------------
    // Field positions and values
    // --------------------------------------------------------------------
    localparam int IDLE_ENABLE_BIT   = 31;
    localparam int IDLE_CLEAR_BIT    = 31;
    localparam int IRQ_ENABLE_BIT    = 13;
    localparam int IRQ_STATUS_BIT    = 12;
    localparam int IRQ_PRIO_LSB      = 5;
    localparam int IRQ_PRIO_MSB      = 7;
    localparam logic [CTX_ID_WIDTH-1:0] MASTER_CTX = 3'h0;
    localparam logic [OBJ_WIDTH-1:0]    OBJ_NONE   = 12'h000;
    localparam logic [OBJ_WIDTH-1:0]    OBJ_SLEEP  = 12'hFFF;
    localparam logic [31:0]             RESET_WORD = 32'h00000000;
    localparam logic [31:0]             UNMAPPED_WORD = 32'h00000000;

    // Scheduler-facing view of one context
    typedef struct packed {
        logic [PRIO_WIDTH-1:0] effective_priority;
        logic                  held;
        logic                  make_not_ready;
        logic                  wake;
        logic                  irq_request;
        logic [PRIO_WIDTH-1:0] irq_priority;
    } sched_out_type;

    // Per-context inputs from the scheduler
    typedef struct packed {
        logic [PRIO_WIDTH-1:0] control_priority;
        logic [PRIO_WIDTH-1:0] status_level;
    } sched_in_type;

endpackage

// [verilog/context_claim_idle_swint.sv]
// Idle timer, resource claim with priority inheritance, software interrupts
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module context_claim_idle_swint
    import ctx_claim_pkg::*;
#(
    parameter int NUM_CONTEXTS = NUM_CTX
)
(
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    reset,
    // Wishbone classic slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [ADDR_WIDTH-1:0]   wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    input  wire logic [CTX_ID_WIDTH-1:0] bus_ctx_id,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    // Scheduler link
    input  wire logic [NUM_CONTEXTS-1:0] ctx_active,
    input  wire sched_in_type            sched_in [NUM_CONTEXTS],
    output sched_out_type                sched_out [NUM_CONTEXTS]
);

    // --------------------------------------------------------------------
    // Bus decode
    // --------------------------------------------------------------------
    wire        bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        wr_req    = bus_req && wb_we_i;
    wire        rd_req    = bus_req && !wb_we_i;
    wire [7:0]  bank      = wb_adr_i & BANK_MASK;
    wire [2:0]  slot      = wb_adr_i[4:2];
    wire        slot_ok   = (32'(slot) < NUM_CONTEXTS) && (wb_adr_i[1:0] == 2'h0);
    wire        claim_ok  = slot_ok && (slot != MASTER_CTX);
    wire        hit_en    = (wb_adr_i == TIMER_ENABLE_OFFSET);
    wire        hit_clr   = (wb_adr_i == TIMER_CLEAR_OFFSET);
    wire        hit_idle  = (wb_adr_i == IDLE_COUNT_OFFSET);
    wire        hit_claim = (bank == CLAIM_BASE) && claim_ok;
    wire        hit_inh   = (bank == INHERIT_BASE) && claim_ok;
    wire        hit_pend  = (bank == PENDING_BASE) && claim_ok;
    wire        hit_ctl   = (bank == IRQ_CONTROL_BASE) && slot_ok;
    wire        hit_mbox  = (bank == IRQ_MAILBOX_BASE) && slot_ok;
    wire        full_word = (wb_sel_i == 4'hF);
    // Byte-lane merge: narrow writes only touch selected lanes
    wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // --------------------------------------------------------------------
    // Idle timer
    // --------------------------------------------------------------------
    logic                  idle_timer_enable;
    logic [DIV_WIDTH-1:0]  idle_div;
    logic [IDLE_WIDTH-1:0] idle_count;

    wire idle_timer_clear = wr_req && hit_clr && wb_sel_i[3] && wb_dat_i[IDLE_CLEAR_BIT];
    wire idle_run         = idle_timer_enable && (ctx_active == '0);
    wire idle_tick        = idle_run && (idle_div == DIV_WIDTH'(IDLE_DIV - 1));

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            idle_timer_enable <= 1'b0;
        else if (wr_req && hit_en && wb_sel_i[3])
            idle_timer_enable <= wb_dat_i[IDLE_ENABLE_BIT];
    end

    // Only the clear strobe and the tick move the count; bus writes do not
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            idle_div   <= '0;
            idle_count <= '0;
        end
        else if (idle_timer_clear)
        begin
            idle_div   <= '0;
            idle_count <= '0;
        end
        else if (idle_run)
        begin
            idle_div <= idle_div + DIV_WIDTH'(1);
            if (idle_tick)
                idle_count <= idle_count + IDLE_WIDTH'(1);
        end
    end

    // --------------------------------------------------------------------
    // Claim, pending and inheritance state
    // --------------------------------------------------------------------
    logic [OBJ_WIDTH-1:0]    claim_obj [NUM_CONTEXTS];
    logic [PRIO_WIDTH-1:0]   inherit   [NUM_CONTEXTS];
    logic [NUM_CONTEXTS-1:0] pending   [NUM_CONTEXTS];
    logic [NUM_CONTEXTS-1:0] not_ready_pulse;
    logic [PRIO_WIDTH-1:0]   eff_prio  [NUM_CONTEXTS];

    // Only the owning context may write its claim register
    wire        claim_wr  = wr_req && hit_claim && full_word && (bus_ctx_id == slot);
    wire [OBJ_WIDTH-1:0] claim_val = wb_dat_i[OBJ_WIDTH-1:0];
    wire        claim_rel = claim_wr && ((claim_val == OBJ_NONE) || (claim_val == OBJ_SLEEP));
    wire        claim_new = claim_wr && !claim_rel;

    // Holder lookup: lowest-numbered match wins, one bus write per cycle
    // already serialises claims, so contention is settled here
    logic                    held_found;
    logic [CTX_ID_WIDTH-1:0] holder;
    always_comb
    begin
        held_found = 1'b0;
        holder     = MASTER_CTX;
        for (int c = NUM_CONTEXTS - 1; c >= 1; c--)
        begin
            if ((c != 32'(slot)) && (claim_obj[c] == claim_val))
            begin
                held_found = 1'b1;
                holder     = CTX_ID_WIDTH'(c);
            end
        end
    end

    wire claim_take     = claim_new && !held_found;
    wire claim_conflict = claim_new && held_found;

    generate
        for (genvar c = 0; c < NUM_CONTEXTS; c++)
        begin : g_ctx
            if (c == 0)
            begin : g_master
                // Master has no claim set
                assign claim_obj[c]       = OBJ_NONE;
                assign inherit[c]         = '0;
                assign pending[c]         = '0;
                assign not_ready_pulse[c] = 1'b0;
            end
            else
            begin : g_claim
                wire own_wr  = (32'(slot) == c);
                wire is_hold = claim_conflict && (32'(holder) == c);
                always_ff @(posedge ref_clk or posedge reset)
                begin
                    if (reset)
                    begin
                        claim_obj[c]       <= OBJ_NONE;
                        inherit[c]         <= '0;
                        pending[c]         <= '0;
                        not_ready_pulse[c] <= 1'b0;
                    end
                    else
                    begin
                        not_ready_pulse[c] <= claim_rel && own_wr && (claim_val == OBJ_SLEEP);
                        if (claim_rel && own_wr)
                        begin
                            claim_obj[c] <= OBJ_NONE;
                            inherit[c]   <= '0;
                            pending[c]   <= '0;
                        end
                        else if (claim_take && own_wr)
                            claim_obj[c] <= claim_val;
                        else if (is_hold)
                        begin
                            pending[c][slot] <= 1'b1;
                            if (eff_prio[slot] > inherit[c])
                                inherit[c] <= eff_prio[slot];
                        end
                    end
                end
            end
        end
    endgenerate

    // --------------------------------------------------------------------
    // Software interrupts
    // --------------------------------------------------------------------
    logic                  irq_enable [NUM_CONTEXTS];
    logic                  irq_status [NUM_CONTEXTS];
    logic [PRIO_WIDTH-1:0] irq_prio   [NUM_CONTEXTS];
    logic [31:0]           mailbox    [NUM_CONTEXTS];

    wire ctl_wr_ok = wr_req && hit_ctl && ((bus_ctx_id == MASTER_CTX) || (bus_ctx_id == slot));
    wire mbox_wr   = wr_req && hit_mbox;
    wire ctl_rd    = rd_req && hit_ctl;

    generate
        for (genvar c = 0; c < NUM_CONTEXTS; c++)
        begin : g_irq
            wire sel_me = (32'(slot) == c);
            always_ff @(posedge ref_clk or posedge reset)
            begin
                if (reset)
                begin
                    irq_enable[c] <= 1'b0;
                    irq_prio[c]   <= '0;
                    irq_status[c] <= 1'b0;
                    mailbox[c]    <= RESET_WORD;
                end
                else
                begin
                    if (ctl_wr_ok && sel_me && wb_sel_i[1])
                        irq_enable[c] <= wb_dat_i[IRQ_ENABLE_BIT];
                    if (ctl_wr_ok && sel_me && wb_sel_i[0])
                        irq_prio[c] <= wb_dat_i[IRQ_PRIO_MSB:IRQ_PRIO_LSB];
                    // A new actuation in the same cycle as the acknowledging read wins
                    if (mbox_wr && sel_me)
                        irq_status[c] <= 1'b1;
                    else if (ctl_rd && sel_me)
                        irq_status[c] <= 1'b0;
                    if (mbox_wr && sel_me)
                        mailbox[c] <= (mailbox[c] & ~lane_mask) | (wb_dat_i & lane_mask);
                end
            end

            // Effective priority and scheduler outputs
            assign eff_prio[c] = (inherit[c] > sched_in[c].control_priority) ?
                                 inherit[c] : sched_in[c].control_priority;
            wire deliver = irq_status[c] && irq_enable[c] &&
                           (irq_prio[c] > sched_in[c].status_level);
            wire held_c;
            if (c == 0)
            begin : g_nohold
                assign held_c = 1'b0;
            end
            else
            begin : g_hold
                logic any_hold;
                always_comb
                begin
                    any_hold = 1'b0;
                    for (int h = 1; h < NUM_CONTEXTS; h++)
                        any_hold = any_hold | pending[h][c];
                end
                assign held_c = any_hold;
            end
            assign sched_out[c] = '{effective_priority: eff_prio[c],
                                    held:               held_c,
                                    make_not_ready:     not_ready_pulse[c],
                                    wake:               deliver,
                                    irq_request:        deliver,
                                    irq_priority:       irq_prio[c]};
        end
    endgenerate

    // --------------------------------------------------------------------
    // Read mux and acknowledge
    // --------------------------------------------------------------------
    logic [31:0] read_word;
    always_comb
    begin
        read_word = UNMAPPED_WORD;
        if (hit_en)
            read_word[IDLE_ENABLE_BIT] = idle_timer_enable;
        else if (hit_clr)
            read_word = RESET_WORD;
        else if (hit_idle)
            read_word[IDLE_WIDTH-1:0] = idle_count;
        else if (hit_claim)
            read_word[OBJ_WIDTH-1:0] = claim_obj[slot];
        else if (hit_inh)
            read_word[PRIO_WIDTH-1:0] = inherit[slot];
        else if (hit_pend)
            read_word[NUM_CONTEXTS-1:0] = pending[slot];
        else if (hit_ctl)
        begin
            read_word[IRQ_ENABLE_BIT]              = irq_enable[slot];
            read_word[IRQ_STATUS_BIT]              = irq_status[slot];
            read_word[IRQ_PRIO_MSB:IRQ_PRIO_LSB]   = irq_prio[slot];
        end
        else if (hit_mbox)
            read_word = mailbox[slot];
    end

    // Unmapped addresses still ack and read zero, so the bus never hangs
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= RESET_WORD;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= rd_req ? read_word : RESET_WORD;
        end
    end

    // --------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------
    a_idle_hold_busy: assert property (@(posedge ref_clk) disable iff (reset)
        (!idle_run && !idle_timer_clear) |=> $stable(idle_count))
        else $error("idle count moved while busy or disabled");
    a_idle_clear_zero: assert property (@(posedge ref_clk) disable iff (reset)
        idle_timer_clear |=> (idle_count == '0))
        else $error("idle clear did not zero count");
    a_idle_tick_rate: assert property (@(posedge ref_clk) disable iff (reset)
        ($changed(idle_count) && !$past(idle_timer_clear)) |-> ($past(idle_div) == DIV_WIDTH'(IDLE_DIV - 1)))
        else $error("idle count ticked off the sixteen-cycle boundary");
    a_idle_step_one: assert property (@(posedge ref_clk) disable iff (reset)
        (idle_tick && !idle_timer_clear) |=> (idle_count == $past(idle_count) + IDLE_WIDTH'(1)))
        else $error("idle count step wrong");
    a_ack_one_cycle: assert property (@(posedge ref_clk) disable iff (reset)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");
    a_ack_answer: assert property (@(posedge ref_clk) disable iff (reset)
        bus_req |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    a_inherit_ro: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_req && hit_inh) |=> (inherit[$past(slot)] == $past(inherit[slot])))
        else $error("inherited priority changed by a bus write");
    a_pending_ro: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_req && hit_pend) |=> (pending[$past(slot)] == $past(pending[slot])))
        else $error("pending flags changed by a bus write");
    a_claim_foreign: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_req && hit_claim && bus_ctx_id != slot) |=> (claim_obj[$past(slot)] == $past(claim_obj[slot])))
        else $error("claim changed by a foreign context");
    a_swirq_ack_clear: assert property (@(posedge ref_clk) disable iff (reset)
        ctl_rd |=> !irq_status[$past(slot)])
        else $error("control read did not clear interrupt status");
    a_ctl_guard: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_req && hit_ctl && bus_ctx_id != MASTER_CTX && bus_ctx_id != slot)
            |=> (irq_prio[$past(slot)] == $past(irq_prio[slot])))
        else $error("control changed by an unauthorised context");
    a_claim_conflict_pend: assert property (@(posedge ref_clk) disable iff (reset)
        claim_conflict |=> pending[$past(holder)][$past(slot)])
        else $error("conflicting claim did not set pending");
    a_claim_release_clr: assert property (@(posedge ref_clk) disable iff (reset)
        (claim_rel && slot != MASTER_CTX) |=> (claim_obj[$past(slot)] == OBJ_NONE && pending[$past(slot)] == '0))
        else $error("release did not clear claim state");
    a_inherit_raise: assert property (@(posedge ref_clk) disable iff (reset)
        claim_conflict |=> (inherit[$past(holder)] >= $past(eff_prio[slot])))
        else $error("holder did not inherit priority");
    a_swirq_raise: assert property (@(posedge ref_clk) disable iff (reset)
        mbox_wr |=> irq_status[$past(slot)])
        else $error("actuation did not raise status");
    a_sleep_not_ready: assert property (@(posedge ref_clk) disable iff (reset)
        (claim_rel && claim_val == OBJ_SLEEP && slot != MASTER_CTX) |=> not_ready_pulse[$past(slot)])
        else $error("all-ones write did not request not ready");

    c_claim_conflict: cover property (@(posedge ref_clk) disable iff (reset) claim_conflict);
    c_claim_release:  cover property (@(posedge ref_clk) disable iff (reset) claim_rel);
    c_idle_tick:      cover property (@(posedge ref_clk) disable iff (reset) idle_tick);
    c_swirq_ack:      cover property (@(posedge ref_clk) disable iff (reset) mbox_wr ##[1:20] ctl_rd);
    c_sleep_request:  cover property (@(posedge ref_clk) disable iff (reset) not_ready_pulse != '0);

endmodule

`default_nettype wire

// [verification/tb.sv]
// Self-checking testbench for the context claim, idle timer and software interrupt block
`timescale 1ns/100ps
`default_nettype none

module tb;
    import ctx_claim_pkg::*;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic                    ref_clk    = 1'b0;
    logic                    reset      = 1'b1;
    logic                    cyc        = 1'b0;
    logic                    stb        = 1'b0;
    logic                    we         = 1'b0;
    logic [ADDR_WIDTH-1:0]   adr        = 8'h00;
    logic [3:0]              sel        = 4'h0;
    logic [31:0]             dat        = 32'h00000000;
    logic [CTX_ID_WIDTH-1:0] ctx_id     = 3'h0;
    logic [NUM_CTX-1:0]      ctx_active = 5'h00;
    logic [31:0]             dat_o;
    logic                    ack;
    sched_in_type            sched_in [NUM_CTX];
    sched_out_type           sched_out [NUM_CTX];
    int                      num_errors = 0;
    int                      checks     = 0;
    int                      seed       = 35397;
    int                      k;
    logic                    sleep_seen = 1'b0;
    logic [31:0]             q;
    logic [31:0]             box;

    always #12.5 ref_clk = ~ref_clk;

    // Sticky catch of the one-cycle not-ready pulse of context two
    always @(posedge ref_clk)
        if (sched_out[2].make_not_ready === 1'b1)
            sleep_seen <= 1'b1;

    context_claim_idle_swint uut (
        .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .bus_ctx_id(ctx_id), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .ctx_active(ctx_active), .sched_in(sched_in), .sched_out(sched_out)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] ra(input logic [7:0] b, input int n);
        ra = b + 8'(n) * CTX_STRIDE;
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Classic cycle: hold everything until ack is sampled high, then release
    task automatic bus(input logic w, input logic [7:0] a, input logic [2:0] id, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        ctx_id <= id;
        dat <= d;
        sel <= 4'hF;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 40);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 40)
            chk("ack wait", 32'h00000001, 32'h00000000);
    endtask

    task automatic rdc(input string name, input logic [7:0] a, input logic [2:0] id, input logic [31:0] e);
        bus(1'b0, a, id, 32'h00000000);
        chk(name, e, q);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #(25 * 30000);
        num_errors++;
        $display("BAD watchdog expected end seen hang");
        close_out;
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        for (int i = 0; i < NUM_CTX; i++)
            sched_in[i] = '{control_priority: 3'(4 - i), status_level: 3'h3};
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        for (int n = 1; n < NUM_CTX; n++)
        begin
            rdc("claim", ra(CLAIM_BASE, n), 3'(n), RESET_WORD);
            rdc("inherit", ra(INHERIT_BASE, n), 3'h0, RESET_WORD);
            rdc("control", ra(IRQ_CONTROL_BASE, n), 3'h0, RESET_WORD);
        end
        bus(1'b1, CLAIM_BASE, 3'h0, 32'h00000123);
        rdc("master claim", CLAIM_BASE, 3'h0, RESET_WORD);
        rdc("unmapped", 8'hFC, 3'h0, UNMAPPED_WORD);
        $display("test reset and map done");
        // Busy contexts keep the idle count still
        ctx_active <= 5'($random(seed)) | 5'h01;
        bus(1'b1, IDLE_COUNT_OFFSET, 3'h0, 32'h00FFFFFF);
        bus(1'b1, TIMER_ENABLE_OFFSET, 3'h0, 32'h80000000);
        rdc("enable", TIMER_ENABLE_OFFSET, 3'h0, 32'h80000000);
        repeat (64) @(posedge ref_clk);
        rdc("idle busy", IDLE_COUNT_OFFSET, 3'h0, RESET_WORD);
        ctx_active <= 5'h00;
        k = 4 + ($random(seed) & 7);
        bus(1'b1, TIMER_CLEAR_OFFSET, 3'h0, 32'h80000000);
        repeat (16 * k) @(posedge ref_clk);
        bus(1'b1, TIMER_ENABLE_OFFSET, 3'h0, 32'h00000000);
        bus(1'b0, IDLE_COUNT_OFFSET, 3'h0, 32'h00000000);
        box = q;
        checks++;
        if ($isunknown(q) || q[31:24] !== 8'h00 || q[23:0] < k || q[23:0] > k + 1)
        begin
            num_errors++;
            $display("BAD idle count expected %0d seen %h", k, q);
        end
        repeat (40) @(posedge ref_clk);
        rdc("idle held", IDLE_COUNT_OFFSET, 3'h0, box);
        bus(1'b1, TIMER_CLEAR_OFFSET, 3'h0, 32'h80000000);
        rdc("idle clr", IDLE_COUNT_OFFSET, 3'h0, RESET_WORD);
        rdc("clear reg", TIMER_CLEAR_OFFSET, 3'h0, RESET_WORD);
        $display("test idle timer done");
        // Claim, conflict, inheritance and release
        box = {20'h00000, 1'b0, 11'($random(seed)) | 11'h001};
        bus(1'b1, ra(CLAIM_BASE, 3), 3'h3, box);
        bus(1'b1, ra(CLAIM_BASE, 3), 3'h2, 32'h00000ABC);
        rdc("claim3", ra(CLAIM_BASE, 3), 3'h3, box);
        bus(1'b1, ra(CLAIM_BASE, 1), 3'h1, box);
        rdc("claim1", ra(CLAIM_BASE, 1), 3'h1, RESET_WORD);
        bus(1'b1, ra(INHERIT_BASE, 3), 3'h0, 32'h00000007);
        bus(1'b1, ra(PENDING_BASE, 3), 3'h0, 32'h00000000);
        rdc("pend3", ra(PENDING_BASE, 3), 3'h0, 32'h00000002);
        rdc("inherit3", ra(INHERIT_BASE, 3), 3'h0, 32'h00000003);
        @(negedge ref_clk);
        chk("held1", 32'h1, {31'h0, sched_out[1].held});
        chk("eff3", 32'h3, {29'h0, sched_out[3].effective_priority});
        bus(1'b1, ra(CLAIM_BASE, 2), 3'h2, box);
        rdc("pend3 two", ra(PENDING_BASE, 3), 3'h0, 32'h00000006);
        rdc("inherit kept", ra(INHERIT_BASE, 3), 3'h0, 32'h00000003);
        bus(1'b1, ra(CLAIM_BASE, 3), 3'h3, 32'h00000000);
        rdc("claim3 rel", ra(CLAIM_BASE, 3), 3'h3, RESET_WORD);
        rdc("pend3 rel", ra(PENDING_BASE, 3), 3'h0, RESET_WORD);
        rdc("inherit rel", ra(INHERIT_BASE, 3), 3'h0, RESET_WORD);
        @(negedge ref_clk);
        chk("held1 rel", 32'h0, {31'h0, sched_out[1].held});
        chk("eff3 rel", 32'h1, {29'h0, sched_out[3].effective_priority});
        bus(1'b1, ra(CLAIM_BASE, 2), 3'h2, box);
        bus(1'b1, ra(CLAIM_BASE, 4), 3'h4, box);
        rdc("pend2", ra(PENDING_BASE, 2), 3'h0, 32'h00000010);
        chk("no sleep", 32'h0, {31'h0, sleep_seen});
        bus(1'b1, ra(CLAIM_BASE, 2), 3'h2, 32'h00000FFF);
        repeat (2) @(posedge ref_clk);
        chk("sleep", 32'h1, {31'h0, sleep_seen});
        rdc("claim2 rel", ra(CLAIM_BASE, 2), 3'h2, RESET_WORD);
        rdc("pend2 rel", ra(PENDING_BASE, 2), 3'h0, RESET_WORD);
        $display("test claim done");
        // Every interrupt priority against status level three
        for (int p = 0; p < 8; p++)
        begin
            bus(1'b1, ra(IRQ_CONTROL_BASE, 2), (p % 2) ? 3'h0 : 3'h2, 32'h00002000 | 32'(p << 5));
            box = $random(seed);
            bus(1'b1, ra(IRQ_MAILBOX_BASE, 2), 3'(p % 5), box);
            @(negedge ref_clk);
            chk("irq req", 32'(p > 3), {31'h0, sched_out[2].irq_request});
            chk("wake", 32'(p > 3), {31'h0, sched_out[2].wake});
            chk("irq prio", 32'(p), {29'h0, sched_out[2].irq_priority});
            rdc("mailbox", ra(IRQ_MAILBOX_BASE, 2), 3'h1, box);
            rdc("ctl pend", ra(IRQ_CONTROL_BASE, 2), 3'h2, 32'h00003000 | 32'(p << 5));
            rdc("ctl ack", ra(IRQ_CONTROL_BASE, 2), 3'h2, 32'h00002000 | 32'(p << 5));
        end
        bus(1'b1, ra(IRQ_CONTROL_BASE, 2), 3'h0, 32'h000000E0);
        bus(1'b1, ra(IRQ_CONTROL_BASE, 2), 3'h1, 32'h00002000);
        bus(1'b1, ra(IRQ_MAILBOX_BASE, 2), 3'h4, 32'h00000000);
        @(negedge ref_clk);
        chk("irq off", 32'h0, {31'h0, sched_out[2].irq_request});
        rdc("ctl guard", ra(IRQ_CONTROL_BASE, 2), 3'h0, 32'h000010E0);
        $display("test software interrupt done");
        close_out;
    end

endmodule
`default_nettype wire
